//--- test_usart_clocking_frame_transmitter.sv
// test_usart_clocking_frame_transmitter: self-checking bench for ucft_core.
// assumes ucft_peer decodes txd; small divisors keep the run short.
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end end
module test_usart_clocking_frame_transmitter;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    ucft_pkg::ucft_cfg_t cfg = '0;
    logic [11:0] baud = 12'h000;
    logic tx_en = 1'b0;
    logic rx_en = 1'b0;
    logic wr_s = 1'b0;
    logic clr = 1'b0;
    logic slave = 1'b0;
    logic [8:0] dat = 9'h000;
    logic [7:0] per = 8'h10;
    logic [3:0] len = 4'hB;
    logic rxd, txd, txd_oe_n, xck_s, xck_m, xck_oe_n, xck_w;
    logic buf_empty, tx_cmp, ferr;
    logic [12:0] got;
    logic [15:0] cnt;
    int err_total = 0;
    int tests_run = 0;
    assign xck_w = xck_oe_n ? xck_s : xck_m;
    always #12.5 i_core_clk = ~i_core_clk;
    ucft_core u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_cfg(cfg), .i_baud_divisor(baud), .i_tx_enable_bit(tx_en),
        .i_rx_enable_bit(rx_en), .i_data_wr(wr_s), .i_data(dat[7:0]),
        .i_tx_ninth_bit(dat[8]), .i_tx_complete_clr(clr), .i_rxd(rxd),
        .o_txd(txd), .o_txd_oe_n(txd_oe_n), .i_sync_clock_pin(xck_w),
        .o_sync_clock_pin(xck_m), .o_sync_clock_oe_n(xck_oe_n),
        .o_tx_buffer_empty_flag(buf_empty), .o_tx_complete_flag(tx_cmp),
        .o_frame_error_flag(ferr), .o_rx_sample(), .o_rx_bit());
    ucft_peer u_peer (.i_clk(i_core_clk), .i_sync(cfg.sync_mode_sel),
        .i_pol(cfg.clock_polarity_sel), .i_slave(slave), .i_per(per),
        .i_len(len), .i_txd(txd), .i_xck(xck_w), .o_rxd(rxd),
        .o_xck(xck_s), .o_frame(got), .o_cnt(cnt));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // poll buffer empty first; ninth bit goes with the low byte
    task automatic wr(input logic [8:0] d);
        for (int w = 0; w < 2000 && buf_empty !== 1'b1; w++)
            @(posedge i_core_clk);
        @(posedge i_core_clk);
        #2 wr_s = 1'b1;
        dat = d;
        @(posedge i_core_clk);
        #2 wr_s = 1'b0;
        `CHK("buffer empty", 1'b0, buf_empty)
    endtask : wr
    task automatic xfer(input logic [8:0] d, input int nd, p, s);
        logic [12:0] f;
        logic par;
        int n;
        int c;
        cfg.char_size_field = (nd == 9) ? ucft_pkg::CHAR_SIZE_9 : 3'(nd - 5);
        cfg.parity_mode_field = (p == 0) ? 2'h0 : {1'b1, p == 2};
        cfg.stop_bits_sel = 1'(s);
        f = 13'h1FFE;
        par = (p == 2);
        for (int k = 0; k < nd; k++) begin
            f[k + 1] = d[k];
            par ^= d[k];
        end
        n = nd + 1;
        if (p != 0) f[n++] = par;
        n = n + 1 + s;
        len = 4'(n);
        c = cnt;
        wr(d);
        for (int w = 0; w < 4000 && cnt == c; w++) @(posedge i_core_clk);
        `CHK("frame", f & ((13'h1 << n) - 13'h1), got)
    endtask : xfer
    // wait for the line to go quiet before any format change
    task automatic done;
        for (int w = 0; w < 600 && tx_cmp !== 1'b1; w++)
            @(posedge i_core_clk);
        #1;
        `CHK("tx complete", 1'b1, tx_cmp)
        `CHK("txd idle", 1'b1, txd)
        `CHK("txd owned", 1'b0, txd_oe_n)
        #1 clr = 1'b1;
        @(posedge i_core_clk);
        #2 clr = 1'b0;
    endtask : done
    task automatic t_formats;
        for (int nd = 5; nd <= 9; nd++)
            for (int p = 0; p < 3; p++)
                for (int s = 0; s < 2; s++) begin
                    xfer(9'h1A5 ^ 9'(nd * 3 + p), nd, p, s);
                    done();
                end
    endtask : t_formats
    task automatic t_double;
        cfg.double_speed_sel = 1'b1;
        per = 8'h08;
        xfer(9'h0C3, 8, 1, 0);
        xfer(9'h13C, 8, 1, 0);
        `CHK("no gap", 1'b0, tx_cmp)
        done();
    endtask : t_double
    task automatic t_rxerr;
        rx_en = 1'b1;
        for (int ds = 0; ds < 2; ds++) begin
            cfg.double_speed_sel = 1'(ds);
            per = ds ? 8'h08 : 8'h10;
            cfg.stop_bits_sel = 1'b0;
            cfg.parity_mode_field = 2'h0;
            cfg.char_size_field = 3'h3;
            u_peer.send({3'b111, 1'b0, 8'h55, 1'b0}, 10);
            repeat (4) @(posedge i_core_clk);
            `CHK("frame error", 1'b1, ferr)
            cfg.stop_bits_sel = 1'b1;
            u_peer.send({2'b11, 1'b0, 1'b1, 8'hAA, 1'b0}, 11);
            repeat (4) @(posedge i_core_clk);
            `CHK("second stop", 1'b0, ferr)
            repeat (200) @(posedge i_core_clk);
        end
        rx_en = 1'b0;
    endtask : t_rxerr
    task automatic t_sync;
        cfg.sync_mode_sel = 1'b1;
        cfg.double_speed_sel = 1'b0;
        baud = 12'h001;
        for (int m = 1; m >= 0; m--)
            for (int pl = 0; pl < 2; pl++) begin
                cfg.clock_pin_direction = 1'(m);
                cfg.clock_polarity_sel = 1'(pl);
                slave = !m;
                xfer(9'h0B4 ^ 9'(pl), 8, 2, 0);
                `CHK("clock pin", 1'(!m), xck_oe_n)
                done();
            end
        // tx stays off with nothing queued, so both pins are freed
        tx_en = 1'b0;
        repeat (20) @(posedge i_core_clk);
        `CHK("txd freed", 1'b1, txd_oe_n)
        `CHK("clock freed", 1'b1, xck_oe_n)
    endtask : t_sync
    initial begin
        repeat (5) @(posedge i_core_clk);
        #2 i_sys_rst = 1'b0;
        // no interrupts here, so setup is never disturbed
        tx_en = 1'b1;
        t_formats();
        t_double();
        t_rxerr();
        t_sync();
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge i_core_clk);
        err_total++;
        finish_test();
    end
endmodule : test_usart_clocking_frame_transmitter
`default_nettype wire

//--- ucft_core.sv
// ucft_core: clock generation, external clock sync, rx sampling, transmitter.
// assumes cfg is quasi-static and changed only with the link idle.
//
// Contract
// - double speed in async mode divides baud output by 8, not 16
// - double speed applies to asynchronous mode only
// - double speed receiver takes 8 samples per bit instead of 16; rx here takes one sample per bit, at phase 3 (phase 7 at normal speed)
// - slave clock passes sync register and edge detector, two clock delay
// - sync mode: clock pin is output as master, input as slave
// - rx samples on the clock edge opposite the tx change edge
// - polarity clear: change rising, sample falling; set: reverse
// - all 30 formats: 5 to 9 data, parity none/even/odd, 1 or 2 stops
// - frame order: start, data lsb first, parity, stop bits
// - after frame end next frame at once or hold line idle high
// - transmitter and receiver share one frame format setting
// - receiver ignores second stop, frame error only on first stop low
// - parity is xor of data bits, inverted for odd parity
// - tx enable takes over serial output pin
// - tx enable in sync master mode takes over the transfer clock pin
// - buffer write loads tx buffer, moves to shifter when idle or done
// - unused upper bits ignored for characters under eight bits
// - transmitter bit clock is baud output divided by 2, 8 or 16
// - clock pin direction picks internal master or external slave clock
// - buffer empty clears on write, sets on move to shifter
`default_nettype none
module ucft_core #(
    parameter int BAUD_W = ucft_pkg::BAUD_W
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // configuration
    input wire ucft_pkg::ucft_cfg_t i_cfg,
    input wire logic [BAUD_W-1:0] i_baud_divisor,
    input wire logic i_tx_enable_bit,
    input wire logic i_rx_enable_bit,
    // transmit data buffer write and tx complete clear
    input wire logic i_data_wr,
    input wire logic [7:0] i_data,
    input wire logic i_tx_ninth_bit,
    input wire logic i_tx_complete_clr,
    // serial pins
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_txd_oe_n,
    input wire logic i_sync_clock_pin,
    output logic o_sync_clock_pin,
    output logic o_sync_clock_oe_n,
    // status
    output logic o_tx_buffer_empty_flag,
    output logic o_tx_complete_flag,
    output logic o_frame_error_flag,
    output logic o_rx_sample,
    output logic o_rx_bit
);
    // baud generator down-counter
    logic [BAUD_W-1:0] baud_cnt_ff;
    wire baud_tick = (baud_cnt_ff == '0);
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) baud_cnt_ff <= BAUD_W'(ucft_pkg::BAUD_RST);
        else if (baud_tick) baud_cnt_ff <= i_baud_divisor;
        else baud_cnt_ff <= baud_cnt_ff - 1'b1;
    end

    wire sync_mode = i_cfg.sync_mode_sel;
    wire master = i_cfg.clock_pin_direction;
    // double speed ignored in sync mode
    wire dbl = i_cfg.double_speed_sel & ~sync_mode;
    wire slave = sync_mode & ~master;

    // phase divider: ticks per bit 16, 8 or 2
    logic [4:0] phase_ff;
    wire [4:0] div_last = sync_mode ? 5'(ucft_pkg::DIV_SYNC_MASTER - 1) :
        dbl ? 5'(ucft_pkg::DIV_ASYNC_DOUBLE - 1) :
        5'(ucft_pkg::DIV_ASYNC_NORMAL - 1);
    // a mode change restarts the bit so no short or long first bit escapes
    logic [4:0] div_last_ff;
    wire div_same = (div_last == div_last_ff);
    wire phase_wrap = baud_tick & div_same & (phase_ff == div_last);
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            phase_ff <= ucft_pkg::PHASE_RST;
            div_last_ff <= ucft_pkg::PHASE_RST;
        end else begin
            div_last_ff <= div_last;
            if (phase_wrap | ~div_same) phase_ff <= ucft_pkg::PHASE_RST;
            else if (baud_tick) phase_ff <= phase_ff + 5'h01;
        end
    end
    wire [4:0] mid_phase = dbl ? 5'h03 : 5'h07;

    // master sync clock: toggles on every baud tick, twice per bit
    logic xcko_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) xcko_ff <= 1'b0;
        else if (baud_tick & sync_mode) xcko_ff <= ~xcko_ff;
    end

    // external clock: sync register then edge detect
    logic xck_s1_ff, xck_s2_ff, xck_s3_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            xck_s1_ff <= 1'b0;
            xck_s2_ff <= 1'b0;
            xck_s3_ff <= 1'b0;
        end else begin
            xck_s1_ff <= i_sync_clock_pin;
            xck_s2_ff <= xck_s1_ff;
            xck_s3_ff <= xck_s2_ff;
        end
    end
    // slave relies on pin below a quarter of core clock
    wire xck_rise_ext = xck_s2_ff & ~xck_s3_ff;
    wire xck_fall_ext = ~xck_s2_ff & xck_s3_ff;
    wire xck_rise_int = baud_tick & sync_mode & ~xcko_ff;
    wire xck_fall_int = baud_tick & sync_mode & xcko_ff;
    wire xck_rise = slave ? xck_rise_ext : xck_rise_int;
    wire xck_fall = slave ? xck_fall_ext : xck_fall_int;
    // polarity picks change and sample edges
    wire sync_change = i_cfg.clock_polarity_sel ? xck_fall : xck_rise;
    wire sync_sample = i_cfg.clock_polarity_sel ? xck_rise : xck_fall;

    wire tx_step = sync_mode ? sync_change : phase_wrap;

    // rx input sampling; shared format, data path lives elsewhere
    logic rxd_s1_ff, rxd_s2_ff, rx_sample_ff, rx_bit_ff;
    wire rx_take = i_rx_enable_bit & (sync_mode ? sync_sample :
        (baud_tick & (phase_ff == mid_phase)));
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rx_sample_ff <= 1'b0;
            rx_bit_ff <= 1'b1;
        end else begin
            rxd_s1_ff <= i_rxd;
            rxd_s2_ff <= rxd_s1_ff;
            rx_sample_ff <= rx_take;
            if (rx_take) rx_bit_ff <= rxd_s2_ff;
        end
    end
    assign o_rx_sample = rx_sample_ff;
    assign o_rx_bit = rx_bit_ff;

    // data width mask and parity
    function automatic logic [8:0] ucft_mask(input logic [2:0] size);
        unique case (size)
            3'h0: ucft_mask = 9'h01F;
            3'h1: ucft_mask = 9'h03F;
            3'h2: ucft_mask = 9'h07F;
            3'h3: ucft_mask = 9'h0FF;
            3'h7: ucft_mask = 9'h1FF;
            default: ucft_mask = 9'h0FF;
        endcase
    endfunction : ucft_mask
    function automatic logic [3:0] ucft_nbits(input logic [2:0] size);
        ucft_nbits = (size == ucft_pkg::CHAR_SIZE_9) ? 4'h9 :
            (size > 3'h3) ? 4'h8 : 4'(size) + 4'h5;
    endfunction : ucft_nbits

    wire [8:0] char_mask = ucft_mask(i_cfg.char_size_field);
    wire [3:0] nbits = ucft_nbits(i_cfg.char_size_field);
    wire parity_en = i_cfg.parity_mode_field[1];
    wire parity_odd = i_cfg.parity_mode_field[0];

    // transmit buffer and shifter
    logic [8:0] tx_buf_ff;
    logic buf_full_ff;
    logic [8:0] shift_ff;
    logic [3:0] bitcnt_ff;
    logic par_ff;
    logic txd_ff;
    logic tx_done_ff;
    logic frame_err_ff;
    ucft_pkg::ucft_tx_state_t st_ff, nxt_st;

    wire [8:0] wr_word = {i_tx_ninth_bit, i_data} & char_mask;
    wire frame_end = tx_step & ((st_ff == ucft_pkg::TX_STOP1 &
        ~i_cfg.stop_bits_sel) | st_ff == ucft_pkg::TX_STOP2);
    wire shifter_free = (st_ff == ucft_pkg::TX_IDLE) | frame_end;
    wire load = buf_full_ff & shifter_free & i_tx_enable_bit &
        (st_ff != ucft_pkg::TX_IDLE | tx_step);
    wire par_bit = ^(tx_buf_ff & char_mask) ^ parity_odd;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ucft_pkg::TX_IDLE: if (load) nxt_st = ucft_pkg::TX_START;
            ucft_pkg::TX_START: if (tx_step) nxt_st = ucft_pkg::TX_DATA;
            ucft_pkg::TX_DATA:
                if (tx_step & bitcnt_ff == nbits - 4'h1)
                    nxt_st = parity_en ? ucft_pkg::TX_PARITY :
                        ucft_pkg::TX_STOP1;
            ucft_pkg::TX_PARITY: if (tx_step) nxt_st = ucft_pkg::TX_STOP1;
            ucft_pkg::TX_STOP1:
                if (tx_step)
                    nxt_st = i_cfg.stop_bits_sel ? ucft_pkg::TX_STOP2 :
                        load ? ucft_pkg::TX_START : ucft_pkg::TX_IDLE;
            ucft_pkg::TX_STOP2:
                if (tx_step)
                    nxt_st = load ? ucft_pkg::TX_START :
                        ucft_pkg::TX_IDLE;
            default: nxt_st = ucft_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_ff <= ucft_pkg::TX_IDLE;
            tx_buf_ff <= ucft_pkg::DATA_RST;
            buf_full_ff <= 1'b0;
            shift_ff <= ucft_pkg::DATA_RST;
            bitcnt_ff <= ucft_pkg::BITCNT_RST;
            par_ff <= 1'b0;
            txd_ff <= 1'b1;
            tx_done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            // a write in the load cycle refills the freed slot
            if (i_data_wr) begin
                tx_buf_ff <= wr_word;
                buf_full_ff <= 1'b1;
            end else if (load) buf_full_ff <= 1'b0;
            if (load) begin
                shift_ff <= tx_buf_ff & char_mask;
                par_ff <= par_bit;
            end else if (tx_step & st_ff == ucft_pkg::TX_DATA)
                shift_ff <= {1'b0, shift_ff[8:1]};
            if (nxt_st != ucft_pkg::TX_DATA) bitcnt_ff <= ucft_pkg::BITCNT_RST;
            else if (tx_step & st_ff == ucft_pkg::TX_DATA)
                bitcnt_ff <= bitcnt_ff + 4'h1;
            unique case (nxt_st)
                ucft_pkg::TX_START: txd_ff <= 1'b0;
                ucft_pkg::TX_DATA:
                    txd_ff <= (tx_step & st_ff == ucft_pkg::TX_DATA) ?
                        shift_ff[1] : shift_ff[0];
                ucft_pkg::TX_PARITY: txd_ff <= par_ff;
                default: txd_ff <= 1'b1;
            endcase
            // set wins over software clear
            if (frame_end & ~load) tx_done_ff <= 1'b1;
            else if (i_tx_complete_clr) tx_done_ff <= 1'b0;
        end
    end

    // stop-bit check on first stop only, second ignored
    logic [3:0] rx_pos_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rx_pos_ff <= ucft_pkg::BITCNT_RST;
            frame_err_ff <= 1'b0;
        end else if (rx_take) begin
            if (rx_pos_ff == ucft_pkg::BITCNT_RST) begin
                if (~rxd_s2_ff) rx_pos_ff <= 4'h1;
            end else if (rx_pos_ff == nbits + 4'(parity_en) + 4'h1) begin
                frame_err_ff <= ~rxd_s2_ff;
                rx_pos_ff <= ucft_pkg::BITCNT_RST;
            end else rx_pos_ff <= rx_pos_ff + 4'h1;
        end
    end

    // pins: transmitter keeps pin until pending work drains
    wire tx_own = i_tx_enable_bit | buf_full_ff | st_ff != ucft_pkg::TX_IDLE;
    assign o_txd = txd_ff;
    assign o_txd_oe_n = ~tx_own;
    assign o_sync_clock_pin = xcko_ff;
    assign o_sync_clock_oe_n = ~(sync_mode & master & tx_own);
    assign o_tx_buffer_empty_flag = ~buf_full_ff;
    assign o_tx_complete_flag = tx_done_ff;
    assign o_frame_error_flag = frame_err_ff;

    AST_DIV_NORMAL: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) (phase_wrap & ~sync_mode & ~dbl)
        |-> phase_ff == 5'h0F) else $error("normal divide not 16");
    AST_DIV_DOUBLE: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) (phase_wrap & dbl)
        |-> phase_ff == 5'h07 | phase_ff == 5'h08)
        else $error("double divide not 8");
    AST_DBL_SYNC: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) sync_mode |-> ~dbl)
        else $error("double speed active in sync");
    AST_SYNC_EDGE: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) (slave & xck_s2_ff & ~xck_s3_ff)
        |-> $past(xck_s1_ff) & ~$past(xck_s2_ff))
        else $error("edge detect not synchronised");
    AST_EDGE_OPP: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) sync_mode |-> ~(sync_change & sync_sample))
        else $error("sample and change same edge");
    AST_START_LOW: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) (st_ff == ucft_pkg::TX_START) |-> ~o_txd)
        else $error("start bit not low");
    AST_IDLE_HIGH: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) (st_ff == ucft_pkg::TX_IDLE & ~load) |=> o_txd)
        else $error("idle line not high");
    AST_UDRE_SET: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) (load & ~i_data_wr) |=> o_tx_buffer_empty_flag)
        else $error("buffer empty not set on load");
    AST_UDRE_CLR: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) i_data_wr |=> ~o_tx_buffer_empty_flag)
        else $error("buffer empty not cleared");
    AST_TXD_OWN: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) i_tx_enable_bit |-> ~o_txd_oe_n)
        else $error("tx pin not taken");
endmodule : ucft_core
`default_nettype wire

//--- ucft_peer.sv
// ucft_peer: remote serial partner; captures tx frames, sends rx frames.
// assumes the bench sets bit period, frame length and mode between frames.
`default_nettype none
module ucft_peer (
    // clock and mode
    input wire logic i_clk,
    input wire logic i_sync,
    input wire logic i_pol,
    input wire logic i_slave,
    input wire logic [7:0] i_per,
    input wire logic [3:0] i_len,
    // serial lines
    input wire logic i_txd,
    input wire logic i_xck,
    output logic o_rxd,
    output logic o_xck,
    // captured frame, first line bit in bit 0
    output logic [12:0] o_frame,
    output logic [15:0] o_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] dv = 2'h0;
    int k;
    initial begin
        o_rxd = 1'b1;
        o_xck = 1'b0;
        o_cnt = 16'h0000;
    end
    // slave clock at an eighth of core, inside the quarter limit
    always @(posedge i_clk) begin
        dv <= i_slave ? dv + 2'h1 : 2'h0;
        if (i_slave && dv == 2'h3) o_xck <= ~o_xck;
    end
    // sampling edge is the one opposite the change edge
    task automatic smp;
        do @(i_xck); while (i_xck !== i_pol);
    endtask : smp
    always begin
        @(negedge i_txd);
        if (i_sync) smp(); else repeat (i_per / 2) @(posedge i_clk);
        o_frame = {12'h000, i_txd};
        for (k = 1; k < i_len; k++) begin
            if (i_sync) smp(); else repeat (i_per) @(posedge i_clk);
            o_frame[k] = i_txd;
        end
        o_cnt++;
    end
    // drive one frame, then back to the idle high level
    task automatic send(input logic [12:0] f, input int n);
        for (int j = 0; j < n; j++) begin
            #2 o_rxd = f[j];
            repeat (i_per) @(posedge i_clk);
        end
        #2 o_rxd = 1'b1;
    endtask : send
endmodule : ucft_peer
`default_nettype wire

//--- ucft_pkg.sv
// ucft_pkg: constants and carrier types for the serial clocking/tx block.
// assumes a single core clock; no bus, all settings arrive as ports.
`default_nettype none
package ucft_pkg;
    localparam int DIV_ASYNC_NORMAL = 16;
    localparam int DIV_ASYNC_DOUBLE = 8;
    localparam int DIV_SYNC_MASTER = 2;
    localparam int BAUD_W = 12;
    localparam logic [BAUD_W-1:0] BAUD_RST = 12'h000;
    localparam logic [2:0] CHAR_SIZE_9 = 3'h7;
    localparam logic [3:0] BITCNT_RST = 4'h0;
    localparam logic [4:0] PHASE_RST = 5'h00;
    localparam logic [8:0] DATA_RST = 9'h000;

    typedef struct packed {
        logic sync_mode_sel;
        logic double_speed_sel;
        logic clock_polarity_sel;
        logic clock_pin_direction;
        logic [2:0] char_size_field;
        logic [1:0] parity_mode_field;
        logic stop_bits_sel;
    } ucft_cfg_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP1,
        TX_STOP2
    } ucft_tx_state_t;
endpackage : ucft_pkg
`default_nettype wire
